// ### verilog/incdec_params.svh
/*
  Constants of the increment/decrement/skip execution block: operand widths,
  destination encodings, reset values.
  Assumes inclusion by bare name from the package and the module.
*/
`ifndef INCDEC_PARAMS_SVH
`define INCDEC_PARAMS_SVH

`define DATA_WIDTH       8
`define FILE_ADDR_WIDTH  7
`define DEST_WORKING     1'h0
`define DEST_FILE        1'h1
`define DATA_ONE         8'h01
`define DATA_ZERO        8'h00
`define ZERO_FLAG_RESET  1'h0
`define WORKING_RESET    8'h00

`endif

// ### verilog/incdec_pkg.sv
/*
  Types shared by the increment/decrement/skip execution block.
  Assumes incdec_params.svh is on the include path.
*/
`include "incdec_params.svh"

package incdec_pkg;

  typedef enum logic [1:0] {
    increment_file_op,
    decrement_skip_zero_op,
    increment_skip_zero_op,
    other_op
  } opcode_t;

  typedef struct packed {
    logic                          valid;
    opcode_t                       op;
    logic [`FILE_ADDR_WIDTH-1:0]   file_addr;
    logic                          dest;
    logic [`DATA_WIDTH-1:0]        operand;
  } issue_t;

  typedef struct packed {
    logic                          file_we;
    logic [`FILE_ADDR_WIDTH-1:0]   file_addr;
    logic [`DATA_WIDTH-1:0]        result;
  } file_write_t;

  typedef enum {
    run,
    squash
  } exec_state_t;

  typedef struct packed {
    exec_state_t                   phase;
    logic [`DATA_WIDTH-1:0]        working;
    logic                          zero_flag;
    file_write_t                   file_wr;
    logic                          squashed;
    logic                          busy;
  } exec_regs_t;

endpackage : incdec_pkg

// ### verilog/incdec_exec.sv
/*
  Execution stage for the increment, decrement-and-skip and increment-and-skip
  byte operations of an 8-bit core: result routing, zero flag, skip squash.
  Assumes the decoder presents one instruction per enabled core_clk cycle, with
  the file operand already read, and that the issue it presents while busy is high is the follower, which is dropped.
*/
`include "incdec_params.svh"

module incdec_exec
  import incdec_pkg::*;
#(
  parameter int DATA_W = `DATA_WIDTH
) (
  input  wire logic                        core_clk,
  input  wire logic                        rstn,
  input  wire logic                        clk_en,
  input  wire issue_t                      issue,
  output      logic [`DATA_WIDTH-1:0]      working,
  output      logic                        zero_flag,
  output      file_write_t                 file_wr,
  output      logic                        squashed,
  output      logic                        busy
);

  // ports and the skip test are sized from the header, so only one byte width is served
  if (DATA_W != `DATA_WIDTH) begin : g_width_check
    $error("incdec_exec supports only an 8-bit data width");
  end

  logic [1:0]                  rst_sync;
  logic                        core_rstn;
  exec_regs_t                  r;
  exec_regs_t                  next_r;
  logic                        is_inc_plain;
  logic                        is_dec_skip;
  logic                        is_inc_skip;
  logic                        is_skip;
  logic                        acts;
  logic [`DATA_WIDTH-1:0]      carry;
  logic [`DATA_WIDTH-1:0]      sum;
  logic                        is_zero;
  logic                        take;

  // decode of the three handled operations; anything else is taken as a no-op
  assign is_inc_plain = issue.op == increment_file_op;
  assign is_dec_skip  = issue.op == decrement_skip_zero_op;
  assign is_inc_skip  = issue.op == increment_skip_zero_op;
  assign is_skip      = is_dec_skip || is_inc_skip;
  assign acts         = is_inc_plain || is_skip;
  assign take         = issue.valid && (r.phase == run);

  // one ripple stage per bit: increment carries through set bits, decrement borrows through clear bits
  assign carry[0] = 1'b1;
  for (genvar b = 0; b < `DATA_WIDTH; b++) begin : g_step
    assign sum[b] = issue.operand[b] ^ carry[b];
    if (b < `DATA_WIDTH - 1) begin : g_ripple
      assign carry[b+1] = (issue.operand[b] ^ is_dec_skip) & carry[b];
    end
  end
  // no carry out is kept, so wrapping past 0xff or 0x00 is exactly modulo 256
  assign is_zero = sum == `DATA_ZERO;

  always_comb begin
    next_r = r;
    next_r.file_wr.file_we = 1'b0;
    next_r.squashed = 1'b0;
    unique case (r.phase)
      run: begin
        if (take && acts) begin
          if (issue.dest == `DEST_FILE) begin
            next_r.file_wr.file_we = 1'b1;
            next_r.file_wr.file_addr = issue.file_addr;
            next_r.file_wr.result = sum;
          end else begin
            next_r.working = sum;
          end
          if (is_inc_plain) begin
            next_r.zero_flag = is_zero;
          end
          // skip ops leave zero_flag untouched: hold by omission
          if (is_skip && is_zero) begin
            next_r.phase = squash;
            next_r.busy = 1'b1;
          end
          // non-zero skip results fall through to the next issue
        end
      end
      squash: begin
        // the fetched follower is discarded as a no-op cycle
        next_r.squashed = 1'b1;
        next_r.busy = 1'b0;
        next_r.phase = run;
      end
    endcase
  end

  // kept apart from the state struct: it runs on rstn itself and ignores clk_en
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  // asserts at once, releases on an edge so no state flop sees a runt release
  assign core_rstn = rst_sync[1];

  always_ff @(posedge core_clk or negedge core_rstn) begin
    if (!core_rstn) begin
      r.phase <= run;
      r.working <= `WORKING_RESET;
      r.zero_flag <= `ZERO_FLAG_RESET;
      r.file_wr <= '0;
      r.squashed <= 1'b0;
      r.busy <= 1'b0;
    end else if (clk_en) begin
      r.phase <= next_r.phase;
      r.working <= next_r.working;
      r.zero_flag <= next_r.zero_flag;
      r.file_wr <= next_r.file_wr;
      r.squashed <= next_r.squashed;
      r.busy <= next_r.busy;
    end
  end

  assign working = r.working;
  assign zero_flag = r.zero_flag;
  assign file_wr = r.file_wr;
  assign squashed = r.squashed;
  assign busy = r.busy;

endmodule : incdec_exec

// ### testbench/incdec_checker.sv
/* port assertions for incdec_exec, bound onto every instance of it; assumes no issue in the two edges after rstn rises */
module incdec_checker import incdec_pkg::*; (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        clk_en,
  input wire issue_t      issue,
  input wire logic [7:0]  working,
  input wire logic        zero_flag,
  input wire file_write_t file_wr,
  input wire logic        squashed,
  input wire logic        busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire       take = clk_en && issue.valid && !busy;
  wire [7:0] inc  = issue.operand + 8'h01;
  wire [7:0] dec  = issue.operand - 8'h01;
  a_inc_working: assert property (take && issue.op == increment_file_op && !issue.dest
    |=> working == $past(inc) && zero_flag == !working) else $error("inc");
  a_file_writeback: assert property (take && issue.dest && issue.op != other_op
    |=> file_wr.file_we && file_wr.file_addr == $past(issue.file_addr)) else $error("wb");
  a_dec_result: assert property (take && issue.op == decrement_skip_zero_op && issue.dest
    |=> file_wr.result == $past(dec)) else $error("dec");
  a_skip_flag: assert property (take && issue.op inside {decrement_skip_zero_op, increment_skip_zero_op}
    |=> $stable(zero_flag)) else $error("flag");
  a_incskip_result: assert property (take && issue.op == increment_skip_zero_op && !issue.dest
    |=> working == $past(inc)) else $error("incsz");
  a_nonzero_run: assert property (take && (issue.op == decrement_skip_zero_op && |dec
    || issue.op == increment_skip_zero_op && |inc) |=> !busy) else $error("run");
  a_zero_skip: assert property (take && (issue.op == decrement_skip_zero_op && !dec
    || issue.op == increment_skip_zero_op && !inc) |=> busy) else $error("skip");
  a_squash_pulse: assert property (busy && clk_en |=> squashed && !busy) else $error("squash");
endmodule : incdec_checker

bind incdec_exec incdec_checker i_incdec_checker (.core_clk, .rstn, .clk_en, .issue, .working, .zero_flag,
  .file_wr, .squashed, .busy);

// ### testbench/increment_decrement_skip_ops_bench.sv
/* random issue stream against a bench model, driven on the falling edge; assumes a two-edge internal reset release */
module increment_decrement_skip_ops_bench import incdec_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 0, rstn = 0, clk_en = 0, took, zero_flag, squashed, busy;
  logic        ez = 0, eb = 0, esq = 0, ewe = 0;
  logic [7:0]  working, r, ew = 0, er = 0;
  logic [6:0]  ea = 0;
  logic [26:0] got, exp;
  issue_t      issue = '0;
  file_write_t file_wr;
  int          bad_count = 0, checks = 0, cyc = 0, seed = 32'h1c9e_ba6d;
  always #2 core_clk = ~core_clk;
  incdec_exec i_incdec_exec (.core_clk, .rstn, .clk_en, .issue, .working, .zero_flag, .file_wr, .squashed, .busy);
  function automatic logic [7:0] calc(issue_t i);
    return i.op == decrement_skip_zero_op ? i.operand - 8'h01 : i.operand + 8'h01;
  endfunction : calc
  task report_and_stop;
    if (bad_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc > 1000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (2) @(negedge core_clk);
    rstn = 1;
    repeat (3) @(negedge core_clk);
    for (int n = 0; n < 400; n++) begin
      issue = 19'($random(seed));
      issue.valid = |2'($random(seed));
      // wrap corners come often: 01 and ff give zero results
      if (n % 4 < 2) issue.operand = n[0] ? 8'hff : 8'h01;
      clk_en = |3'($random(seed));
      took = clk_en && issue.valid && !eb;
      r = calc(issue);
      if (clk_en) begin
        esq = eb;
        ewe = took && issue.dest && issue.op != other_op;
        if (ewe) begin
          er = r;
          ea = issue.file_addr;
        end
        if (took && issue.op != other_op && !issue.dest) ew = r;
        if (took && issue.op == increment_file_op) ez = r == 8'h00;
        eb = took && issue.op inside {decrement_skip_zero_op, increment_skip_zero_op} && r == 8'h00;
      end
      @(negedge core_clk);
      got = {working, zero_flag, busy, squashed, file_wr.file_we, file_wr.file_addr, file_wr.result};
      exp = {ew, ez, eb, esq, ewe, ea, er};
      checks++;
      if (got !== exp) begin
        bad_count++;
        $display("Error outputs expected %h seen %h", exp, got);
      end
    end
    report_and_stop();
  end
endmodule : increment_decrement_skip_ops_bench
